/* logic/two_wire_unit.v */
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`include "two_wire_defines.vh"
`default_nettype none
// Behaviour
// - done flag set after every start and every byte, not after stop
// - irq only if local and global enable
// - status code valid while flag set
// - write one clears flag, zero keeps
// - no new operation while flag set
// - start commanded operation after flag clear
// - start sent sets flag and code
// - address sent posts ack or nack code
// - data sent posts ack or nack code
// - stop completion leaves flag clear
// - serial clock held low while flag; released when the enable bit is cleared
// - one data register for address and data
// - data write while flag low collides
// - stop request self-clears after stop
module two_wire_unit #(
  parameter QUARTER_CYC = `QUARTER_CYC
) (
  input  wire        CLK_SYS_I,
  input  wire        RST_B_I,
  input  wire        HSEL_I,
  input  wire [7:0]  HADDR_I,
  input  wire [1:0]  HTRANS_I,
  input  wire        HWRITE_I,
  input  wire [2:0]  HSIZE_I,
  input  wire [31:0] HWDATA_I,
  input  wire        HREADY_I,
  output wire [31:0] HRDATA_O,
  output wire        HREADYOUT_O,
  output wire        HRESP_O,
  input  wire        GLOBAL_IRQ_EN_I,
  output wire        IRQ_O,
  input  wire        SCL_I,
  output wire        SCL_O,
  output wire        SCL_OE_O,
  input  wire        SDA_I,
  output wire        SDA_O,
  output wire        SDA_OE_O
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BYTE  = 2'h2;
  localparam ST_STOP  = 2'h3;
  localparam [15:0] TICK_LAST = QUARTER_CYC[15:0] - 16'h0001;

  reg [31:0] hrdata_r;
  reg        hready_r;
  reg        hresp_r;
  reg [5:0]  a_r;
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg [31:0] rd_mux;
  reg        flag_r;
  reg        ack_en_r;
  reg        start_r;
  reg        stop_r;
  reg        coll_r;
  reg        en_r;
  reg        ie_r;
  reg [1:0]  presc_r;
  reg [4:0]  code_r;
  reg [7:0]  data_r;
  reg        irq_r;
  reg [15:0] cnt_r;
  reg        tick_r;
  reg        scl_m_r;
  reg        scl_s_r;
  reg        sda_m_r;
  reg        sda_s_r;
  reg [1:0]  state_r;
  reg [1:0]  q_r;
  reg [3:0]  bit_r;
  reg [7:0]  sh_r;
  reg        first_r;
  reg        owned_r;
  reg        scl_o_r;
  reg        scl_oe_r;
  reg        sda_o_r;
  reg        sda_oe_r;

  assign HRDATA_O    = hrdata_r;
  assign HREADYOUT_O = hready_r;
  assign HRESP_O     = hresp_r;
  assign IRQ_O       = irq_r;
  assign SCL_O       = scl_o_r;
  assign SCL_OE_O    = scl_oe_r;
  assign SDA_O       = sda_o_r;
  assign SDA_OE_O    = sda_oe_r;

  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    rd_mux = 32'h0000_0000;
    case (a_r)
      `IDX_CONTROL: rd_mux[7:0] = {flag_r, ack_en_r, start_r, stop_r,
                                   coll_r, en_r, 1'b0, ie_r};
      `IDX_STATUS:  rd_mux[7:0] = {code_r, 1'b0, presc_r};
      `IDX_DATA:    rd_mux[7:0] = data_r;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // pin synchronisers and quarter-bit divider
  // ****************************************
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      cnt_r   <= 16'h0000;
      tick_r  <= 1'b0;
    end else begin
      scl_m_r <= SCL_I;
      scl_s_r <= scl_m_r;
      sda_m_r <= SDA_I;
      sda_s_r <= sda_m_r;
      tick_r  <= (cnt_r == TICK_LAST);
      if (cnt_r == TICK_LAST) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  // ****************************************
  // bus slave, registers and bus sequencer
  // ****************************************
  // one shared block: software writes and bus events touch the same bits,
  // and later assignments here let hardware events win the same cycle
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      hrdata_r  <= 32'h0000_0000;
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
      a_r       <= 6'h00;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      flag_r    <= 1'b0;
      ack_en_r  <= 1'b0;
      start_r   <= 1'b0;
      stop_r    <= 1'b0;
      coll_r    <= 1'b0;
      en_r      <= 1'b0;
      ie_r      <= 1'b0;
      presc_r   <= `PRESC_RESET;
      code_r    <= `CODE_IDLE;
      data_r    <= `DATA_RESET;
      irq_r     <= 1'b0;
      state_r   <= ST_IDLE;
      q_r       <= 2'h0;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      first_r   <= 1'b0;
      owned_r   <= 1'b0;
      scl_o_r   <= 1'b0;
      scl_oe_r  <= 1'b0;
      sda_o_r   <= 1'b0;
      sda_oe_r  <= 1'b0;
    end else begin
      irq_r <= flag_r & ie_r & GLOBAL_IRQ_EN_I;
      // write data phase, zero wait
      if (wr_pend_r) begin
        wr_pend_r <= 1'b0;
        case (a_r)
          `IDX_CONTROL: begin
            ack_en_r <= HWDATA_I[`CTL_ACK_EN];
            start_r  <= HWDATA_I[`CTL_START];
            stop_r   <= HWDATA_I[`CTL_STOP];
            en_r     <= HWDATA_I[`CTL_ENABLE];
            ie_r     <= HWDATA_I[`CTL_IRQ_EN];
            if (HWDATA_I[`CTL_DONE]) begin
              flag_r <= 1'b0;
            end
          end
          `IDX_STATUS: presc_r <= HWDATA_I[1:0];
          `IDX_DATA: begin
            if (flag_r) begin
              data_r <= HWDATA_I[7:0];
              coll_r <= 1'b0;
            end else begin
              coll_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      // read data phase: one wait state so a just-written value is seen
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        hrdata_r  <= rd_mux;
        hready_r  <= 1'b1;
      end
      // address phase
      if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
        a_r       <= HADDR_I[7:2];
        wr_pend_r <= HWRITE_I && (HSIZE_I == `HSIZE_WORD);
        rd_pend_r <= !HWRITE_I;
        hready_r  <= HWRITE_I;
      end
      // bus sequencer
      if (!en_r) begin
        state_r  <= ST_IDLE;
        q_r      <= 2'h0;
        owned_r  <= 1'b0;
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (!flag_r) begin
              if (start_r && (owned_r || (scl_s_r && sda_s_r))) begin
                state_r <= ST_START;
              end else if (stop_r && owned_r) begin
                state_r <= ST_STOP;
              end else if (stop_r) begin
                stop_r <= 1'b0;
              end else if (owned_r) begin
                state_r <= ST_BYTE;
                sh_r    <= data_r;
                bit_r   <= 4'h0;
              end
              q_r <= 2'h0;
            end
          end
          ST_START: begin
            if (tick_r) begin
              case (q_r)
                2'h0: begin
                  sda_oe_r <= 1'b0;
                  scl_oe_r <= owned_r;
                  q_r      <= 2'h1;
                end
                2'h1: begin
                  scl_oe_r <= 1'b0;
                  q_r      <= 2'h2;
                end
                2'h2: begin
                  if (scl_s_r) begin
                    sda_oe_r <= 1'b1;
                    q_r      <= 2'h3;
                  end
                end
                default: begin
                  scl_oe_r <= 1'b1;
                  owned_r  <= 1'b1;
                  first_r  <= 1'b1;
                  flag_r   <= 1'b1;
                  code_r   <= `CODE_START_SENT;
                  state_r  <= ST_IDLE;
                  q_r      <= 2'h0;
                end
              endcase
            end
          end
          ST_BYTE: begin
            if (tick_r) begin
              case (q_r)
                2'h0: begin
                  sda_oe_r <= (bit_r < 4'h8) ? ~sh_r[7] : 1'b0;
                  q_r      <= 2'h1;
                end
                2'h1: begin
                  scl_oe_r <= 1'b0;
                  q_r      <= 2'h2;
                end
                2'h2: begin
                  // slave may stretch: wait for the line to really rise
                  if (scl_s_r) begin
                    if (bit_r == 4'h8) begin
                      if (first_r) begin
                        code_r <= sda_s_r ? `CODE_ADDR_NACK : `CODE_ADDR_ACK;
                      end else begin
                        code_r <= sda_s_r ? `CODE_DATA_NACK : `CODE_DATA_ACK;
                      end
                    end
                    q_r <= 2'h3;
                  end
                end
                default: begin
                  scl_oe_r <= 1'b1;
                  q_r      <= 2'h0;
                  if (bit_r == 4'h8) begin
                    flag_r  <= 1'b1;
                    first_r <= 1'b0;
                    state_r <= ST_IDLE;
                  end else begin
                    bit_r <= bit_r + 4'h1;
                    sh_r  <= {sh_r[6:0], 1'b0};
                  end
                end
              endcase
            end
          end
          ST_STOP: begin
            if (tick_r) begin
              case (q_r)
                2'h0: begin
                  sda_oe_r <= 1'b1;
                  q_r      <= 2'h1;
                end
                2'h1: begin
                  scl_oe_r <= 1'b0;
                  q_r      <= 2'h2;
                end
                2'h2: begin
                  if (scl_s_r) begin
                    sda_oe_r <= 1'b0;
                    q_r      <= 2'h3;
                  end
                end
                default: begin
                  stop_r  <= 1'b0;
                  owned_r <= 1'b0;
                  code_r  <= `CODE_IDLE;
                  state_r <= ST_IDLE;
                  q_r     <= 2'h0;
                end
              endcase
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // two_wire_unit
`default_nettype wire

/* logic/two_wire_defines.vh */
`ifndef TWO_WIRE_DEFINES_VH
`define TWO_WIRE_DEFINES_VH
// ****************************************
// register word indexes (byte address = 4 * index)
// ****************************************
`define IDX_CONTROL      6'h00
`define IDX_STATUS       6'h01
`define IDX_DATA         6'h02
// ****************************************
// control_reg field positions
// ****************************************
`define CTL_DONE         7
`define CTL_ACK_EN       6
`define CTL_START        5
`define CTL_STOP         4
`define CTL_COLLISION    3
`define CTL_ENABLE       2
`define CTL_IRQ_EN       0
// ****************************************
// reset values
// ****************************************
`define DATA_RESET       8'hFF
`define PRESC_RESET      2'h0
// ****************************************
// status codes, 5-bit field in status_reg[7:3]
// ****************************************
`define CODE_IDLE        5'h1F
`define CODE_START_SENT  5'h01
`define CODE_ADDR_ACK    5'h03
`define CODE_ADDR_NACK   5'h04
`define CODE_DATA_ACK    5'h05
`define CODE_DATA_NACK   5'h06
// ****************************************
// timing
// ****************************************
`define CLK_MHZ          125
`define QUARTER_NS       2500
`define QUARTER_CYC      ((`QUARTER_NS * `CLK_MHZ + 999) / 1000)
`define HSIZE_WORD       3'h2
`endif

/* test/two_wire_checker.sv */
`default_nettype none
// ********
// port checks
// ********
module two_wire_checker #(
  parameter QUARTER_CYC = 4
) (
  input wire logic       CLK_SYS_I,
  input wire logic       RST_B_I,
  input wire logic       HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic       HWRITE_I,
  input wire logic       HREADY_I,
  input wire logic       HREADYOUT_O,
  input wire logic       HRESP_O,
  input wire logic       GLOBAL_IRQ_EN_I,
  input wire logic       IRQ_O,
  input wire logic       SCL_O,
  input wire logic       SCL_OE_O,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q3 = 3 * QUARTER_CYC;
  wire logic take = HSEL_I & HTRANS_I[1] & HREADY_I;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  sequence rd_wait; !HREADYOUT_O ##1 HREADYOUT_O; endsequence
  sequence start_seen; $rose(SDA_OE_O) && !SCL_OE_O; endsequence
  // a stop, or clearing the enable bit, drops data while the clock is released
  sequence stop_seen; $fell(SDA_OE_O) && !SCL_OE_O; endsequence
  AST_RESP_OKAY: assert property (HRESP_O == 1'b0)
    else $error("response not okay");
  AST_READ_WAIT: assert property (take && !HWRITE_I |=> rd_wait)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (take && HWRITE_I |=> HREADYOUT_O)
    else $error("write stalled");
  AST_IRQ_GLOBAL: assert property (IRQ_O |-> $past(GLOBAL_IRQ_EN_I))
    else $error("irq without global enable");
  AST_HOLD_SCL: assert property (IRQ_O && $past(IRQ_O) |-> SCL_OE_O)
    else $error("clock released while flag set");
  AST_NO_OP: assert property (IRQ_O && $past(IRQ_O) |-> $stable(SDA_OE_O))
    else $error("bus moved while flag set");
  AST_PIN_ZERO: assert property (SCL_O == 1'b0 && SDA_O == 1'b0)
    else $error("open drain value not low");
  AST_START_FLAG: assert property (start_seen |-> ##[1:Q3] SCL_OE_O)
    else $error("start not completed");
  AST_STOP_NOFLAG: assert property (stop_seen |=> !IRQ_O [*8])
    else $error("flag after stop");
endmodule // two_wire_checker
bind two_wire_unit two_wire_checker #(.QUARTER_CYC(QUARTER_CYC)) chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .IRQ_O(IRQ_O),
  .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O));
`default_nettype wire

/* test/slave_model.sv */
`default_nettype none
// ********
// bus slave
// ********
module slave_model (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       ack_en_i,
  input  wire logic       slow_i,
  output var  logic       scl_oe_o,
  output var  logic       sda_oe_o,
  output var  logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  logic [7:0] sh;
  initial begin
    {scl_oe_o, sda_oe_o, rx_o, sh} = 18'h0;
    cnt = 0;
  end
  always @(negedge sda_i) if (scl_i) cnt = 0;
  always @(posedge scl_i) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda_i};
      cnt++;
      if (cnt == 8) rx_o = sh;
    end
  end
  // slow mode stretches every low phase
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      sda_oe_o = ack_en_i;
      cnt = 9;
    end else if (cnt == 9) begin
      sda_oe_o = 1'b0;
      cnt = 0;
    end
    if (slow_i) begin
      scl_oe_o = 1'b1;
      #300;
      scl_oe_o = 1'b0;
    end
  end
endmodule // slave_model
`default_nettype wire

/* test/tb_top.sv */
`include "two_wire_defines.vh"
`default_nettype none
// ********
// bench
// ********
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, hsel, hwrite, gie, ack_en, slow;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  logic        hready, irq, scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  logic [7:0]  rx;
  int          err_total, check_count;
  // released lines float high through the pull-ups
  wire logic scl = !(scl_oe | s_scl_oe);
  wire logic sda = !(sda_oe | s_sda_oe);
  two_wire_unit #(.QUARTER_CYC(4)) dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(`HSIZE_WORD), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(), .GLOBAL_IRQ_EN_I(gie), .IRQ_O(irq),
    .SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe));
  slave_model sl_u (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .slow_i(slow),
    .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe), .rx_o(rx));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata[7:0];
  endtask
  task automatic wait_bit(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] r;
    int         n;
    n = 0;
    r = ~v;
    while ((r & m) !== v && n < 400) begin
      xfer(1'b0, `IDX_CONTROL, 8'h00, r);
      n++;
    end
    chk("control poll", r & m, v);
  endtask
  task automatic send(input logic [7:0] cmd, input logic [4:0] code);
    logic [7:0] r;
    xfer(1'b1, `IDX_CONTROL, cmd, r);
    wait_bit(8'h80, 8'h80);
    xfer(1'b0, `IDX_STATUS, 8'h00, r);
    chk("status", r & 8'hF8, {code, 3'h0});
  endtask
  task automatic sc_regs();
    logic [7:0] r;
    xfer(1'b0, `IDX_CONTROL, 8'h00, r);
    chk("control reset", r, 8'h00);
    xfer(1'b0, `IDX_STATUS, 8'h00, r);
    chk("status reset", r, {`CODE_IDLE, 1'b0, `PRESC_RESET});
    chk("read upper", hrdata[31:24] | hrdata[23:16] | hrdata[15:8], 8'h00);
    xfer(1'b1, `IDX_DATA, 8'h33, r);
    xfer(1'b0, `IDX_DATA, 8'h00, r);
    chk("data dropped", r, `DATA_RESET);
    xfer(1'b0, `IDX_CONTROL, 8'h00, r);
    chk("collision", r, 8'h01 << `CTL_COLLISION);
    xfer(1'b1, 6'h03, 8'h55, r);
    xfer(1'b0, 6'h03, 8'h00, r);
    chk("unmapped", r, 8'h00);
    xfer(1'b1, `IDX_STATUS, 8'h03, r);
    xfer(1'b0, `IDX_STATUS, 8'h00, r);
    chk("prescale", r, 8'hFB);
  endtask
  task automatic sc_write(input logic aa, input logic [7:0] ie, input logic sl);
    logic [7:0] r;
    ack_en <= aa;
    slow <= sl;
    send(8'hA4 | ie, `CODE_START_SENT);
    xfer(1'b1, `IDX_CONTROL, 8'h24 | ie, r);
    repeat (30) @(posedge clk);
    wait_bit(8'h80, 8'h80);
    chk("irq level", {7'h0, irq}, ie);
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk("irq masked", {7'h0, irq}, 8'h00);
    gie <= 1'b1;
    xfer(1'b1, `IDX_DATA, 8'hA4, r);
    send(8'h84 | ie, aa ? `CODE_ADDR_ACK : `CODE_ADDR_NACK);
    chk("addr byte", rx, 8'hA4);
    xfer(1'b1, `IDX_DATA, 8'h5A, r);
    xfer(1'b0, `IDX_CONTROL, 8'h00, r);
    chk("collision clear", r & 8'h08, 8'h00);
    send(8'h84 | ie, aa ? `CODE_DATA_ACK : `CODE_DATA_NACK);
    chk("data byte", rx, 8'h5A);
    xfer(1'b1, `IDX_CONTROL, 8'h94 | ie, r);
    wait_bit(8'h90, 8'h00);
    chk("irq after stop", {7'h0, irq}, 8'h00);
  endtask
  task automatic sc_stray_stop();
    logic [7:0] r;
    xfer(1'b1, `IDX_CONTROL, 8'h94, r);
    wait_bit(8'h90, 8'h00);
    chk("lines idle", {6'h0, scl, sda}, 8'h03);
    xfer(1'b0, `IDX_STATUS, 8'h00, r);
    chk("status idle", r & 8'hF8, {`CODE_IDLE, 3'h0});
    xfer(1'b1, `IDX_CONTROL, 8'h00, r);
    xfer(1'b0, `IDX_CONTROL, 8'h00, r);
    chk("disabled", r, 8'h00);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    close_out();
  end
  initial begin
    {hsel, hwrite, gie, ack_en, slow, rst_b} = 6'h00;
    {haddr, htrans, hwdata} = 42'h0;
    err_total = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    gie <= 1'b1;
    @(posedge clk);
    sc_regs();
    sc_write(1'b1, 8'h01, 1'b0);
    sc_write(1'b0, 8'h00, 1'b1);
    sc_stray_stop();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
